// File: dv/rtec_host_model.sv
// Host model: APB master that reaches the radio task block registers
`timescale 1ns/1ps
`default_nettype none
module rtec_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero so no stray setup cycle is seen
  initial begin
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; the request is held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_rtec_task_end.sv
// Self-checking testbench for the radio task end, capture and gain control block
`timescale 1ns/1ps
`default_nettype none
module tb_rtec_task_end;
  import rtec_pkg::*;
  typedef struct packed {
    logic [3:0] cfg;
    logic [1:0] e0;
    logic [1:0] e1;
    logic [1:0] e2;
    logic [2:0] fl;
  } rtec_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        task_start, task_end, tx_sync_done, tx_packet_end, rx_sync_found, rx_packet_end;
  logic        rx_on, level_update, task_finished_irq, lock_release, synth_on, task_active;
  logic [7:0]  paddr, end_cause_in, level_in, front_end_gain;
  logic [31:0] pwdata, prdata, timer_value, cap_exp;
  int          errors, tests_run;
  // Events: 0 tx start, 1 tx end, 2 rx start, 3 rx end; fl marks events that must capture
  rtec_row_s   rows [9] = '{{4'h0, 2'h0, 2'h2, 2'h3, 3'h0}, {4'h1, 2'h0, 2'h1, 2'h2, 3'h1},
                            {4'h2, 2'h0, 2'h1, 2'h3, 3'h2}, {4'h3, 2'h0, 2'h1, 2'h0, 3'h1},
                            {4'h4, 2'h2, 2'h3, 2'h0, 3'h1}, {4'h8, 2'h2, 2'h3, 2'h1, 3'h2},
                            {4'hC, 2'h2, 2'h3, 2'h2, 3'h1}, {4'hC, 2'h2, 2'h2, 2'h3, 3'h3},
                            {4'h5, 2'h2, 2'h0, 2'h3, 3'h3}};

  rtec_task_end dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .task_start(task_start), .task_end(task_end), .end_cause_in(end_cause_in),
    .tx_sync_done(tx_sync_done), .tx_packet_end(tx_packet_end), .rx_sync_found(rx_sync_found),
    .rx_packet_end(rx_packet_end), .rx_on(rx_on), .level_update(level_update), .level_in(level_in),
    .timer_value(timer_value), .task_finished_irq(task_finished_irq), .lock_release(lock_release),
    .synth_on(synth_on), .task_active(task_active), .front_end_gain(front_end_gain));
  rtec_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 40 MHz clock
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle pulse; raised and dropped right after rising edges so no edge sees a race
  task automatic fire(input int e);
    @(posedge pclk);
    case (e)
      0: tx_sync_done <= 1'h1;
      1: tx_packet_end <= 1'h1;
      2: rx_sync_found <= 1'h1;
      3: rx_packet_end <= 1'h1;
      4: task_start <= 1'h1;
      5: task_end <= 1'h1;
      default: level_update <= 1'h1;
    endcase
    @(posedge pclk);
    {tx_sync_done, tx_packet_end, rx_sync_found, rx_packet_end, task_start, task_end, level_update} <= 7'h00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'h1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input string nm);
    logic [31:0] r;
    logic        e;
    host.xfer(1'h0, a, 32'h0, r, e);
    chk(nm, x, r & m);
  endtask

  // Completion: bounded wait for the finished pulse, then cause and synthesizer state
  task automatic wait_done(input logic [7:0] c, input logic k);
    int n;
    n = 0;
    while (task_finished_irq !== 1'h1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, task_finished_irq});
    chk("lock_release", 32'h1, {31'h0, lock_release});
    rd(ADDR_STATUS, {22'h0, k, 1'h0, c}, 32'h3FF, "status");
  endtask

  task automatic end_task(input logic [7:0] c, input logic k);
    @(posedge pclk);
    end_cause_in <= c;
    fire(5);
    wait_done(c, k);
  endtask

  task automatic lvl(input logic [7:0] v, input logic [7:0] g);
    @(posedge pclk);
    level_in <= v;
    fire(6);
    @(posedge pclk);
    chk("gain", {24'h0, g}, {24'h0, front_end_gain});
  endtask

  // Hang guard, far above the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    summarize();
  end

  initial begin
    {task_start, task_end, tx_sync_done, tx_packet_end, rx_sync_found, rx_packet_end} = 6'h00;
    {rx_on, level_update} = 2'h0;
    {end_cause_in, level_in, timer_value} = 48'h0;
    presetn = 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values and an unmapped address
    rd(ADDR_CONFIG, CONFIG_RESET, 32'hFFFFFFFF, "config");
    rd(ADDR_GAIN_NOW, {24'h0, GAIN_RESET}, 32'hFF, "gain_now");
    host.xfer(1'h0, 8'h40, 32'h0, cap_exp, err);
    chk("slverr", 32'h1, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
    // Capture selector table, one task per row; the value is read only once the task is over
    cap_exp = 32'h0;
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_CONFIG, {28'h0, rows[i].cfg});
      fire(4);
      for (int j = 0; j < 3; j++) begin
        @(posedge pclk);
        timer_value <= 32'h1000 + 32'(i * 16 + j);
        if (rows[i].fl[j]) cap_exp = 32'h1000 + 32'(i * 16 + j);
        fire(j == 0 ? rows[i].e0 : (j == 1 ? rows[i].e1 : rows[i].e2));
      end
      end_task(END_NORMAL, 1'h0);
      rd(ADDR_CAPTURE, cap_exp, 32'hFFFFFFFF, "capture");
    end
    // Every end-cause code
    wr(ADDR_CONFIG, 32'h0);
    for (int i = 0; i < 14; i++) begin
      fire(4);
      end_task(i < 7 ? 8'(i) : ERR_MODULATOR_UNDERFLOW + 8'(i - 7), 1'h0);
    end
    // Two-level gain control; limits kept apart for hysteresis
    wr(ADDR_GAIN_NOW, 32'h3C);
    wr(ADDR_GAIN_CFG, 32'h0511);
    wr(ADDR_LEVEL_LIM, 32'h6020);
    wr(ADDR_CONFIG, 32'h20);
    @(posedge pclk);
    rx_on <= 1'h1;
    fire(4);
    lvl(8'h70, 8'h11);
    lvl(8'h40, 8'h11);
    lvl(8'h10, 8'h3C);
    lvl(8'h70, 8'h11);
    // Gain writes are refused while running; high byte holds the gain captured at start
    wr(ADDR_GAIN_NOW, 32'h77);
    rd(ADDR_GAIN_NOW, 32'h3C11, 32'hFFFF, "gain_now_run");
    fire(2);
    lvl(8'h10, 8'h11);
    @(posedge pclk);
    level_in <= 8'h50;
    fire(3);
    rd(ADDR_LAST_LEVEL, 32'h55, 32'hFF, "last_level");
    @(posedge pclk);
    rx_on <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("gain_restore", 32'h3C, {24'h0, front_end_gain});
    wr(ADDR_COMMAND, {24'h0, HALT_COMMAND});
    wait_done(END_ABORTED, 1'h0);
    // Synthesizer kept on, stopped by halt while running and while idle
    wr(ADDR_CONFIG, 32'h10);
    fire(4);
    end_task(END_NORMAL, 1'h1);
    fire(4);
    wr(ADDR_COMMAND, {24'h0, HALT_COMMAND});
    wait_done(END_ABORTED, 1'h0);
    fire(4);
    end_task(END_NORMAL, 1'h1);
    wr(ADDR_COMMAND, {24'h0, HALT_COMMAND});
    repeat (2) @(posedge pclk);
    chk("synth_idle_halt", 32'h0, {31'h0, synth_on});
    // Reset in the middle of a task
    fire(4);
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    chk("active_reset", 32'h0, {31'h0, task_active});
    presetn <= 1'h1;
    rd(ADDR_CONFIG, CONFIG_RESET, 32'hFFFFFFFF, "config_reset");
    summarize();
  end
endmodule
`default_nettype wire

// File: rtl/rtec_pkg.sv
// Package for the radio task end, capture and gain control block
package rtec_pkg;
  // Capture selector encodings
  localparam logic [1:0] CAP_OFF         = 2'h0;
  localparam logic [1:0] CAP_EVERY_START = 2'h1;
  localparam logic [1:0] CAP_EVERY_END   = 2'h2;
  localparam logic [1:0] CAP_FIRST_START = 2'h3;
  // End-cause codes
  localparam logic [7:0] END_NORMAL              = 8'h00;
  localparam logic [7:0] END_SYNC_WAIT_STOPPED   = 8'h01;
  localparam logic [7:0] END_NO_SYNC             = 8'h02;
  localparam logic [7:0] END_CHANNEL_BUSY        = 8'h03;
  localparam logic [7:0] END_RETRY_LIMIT         = 8'h04;
  localparam logic [7:0] END_GRACEFUL_STOP       = 8'h05;
  localparam logic [7:0] END_ABORTED             = 8'h06;
  localparam logic [7:0] ERR_INTERNAL            = 8'hFF;
  localparam logic [7:0] ERR_UNKNOWN_COMMAND     = 8'hFE;
  localparam logic [7:0] ERR_LOCK_UNAVAILABLE    = 8'hFD;
  localparam logic [7:0] ERR_BAD_PARAMETER       = 8'hFC;
  localparam logic [7:0] ERR_TX_QUEUE_EMPTY      = 8'hFB;
  localparam logic [7:0] ERR_RX_QUEUE_OVERFULL   = 8'hFA;
  localparam logic [7:0] ERR_MODULATOR_UNDERFLOW = 8'hF9;
  // Commands
  localparam logic [7:0] HALT_COMMAND = 8'h01;
  // Channel value that reuses a running synthesizer
  localparam logic [6:0] CHANNEL_REUSE = 7'h7F;
  // Radio configuration word field positions
  localparam int TX_CAP_LSB = 0;
  localparam int RX_CAP_LSB = 2;
  localparam int SYNTH_KEEP_BIT = 4;
  localparam int GAIN_EN_BIT = 5;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CONFIG     = 8'h00;
  localparam logic [7:0] ADDR_COMMAND    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE    = 8'h0C;
  localparam logic [7:0] ADDR_GAIN_CFG   = 8'h10;
  localparam logic [7:0] ADDR_LEVEL_LIM  = 8'h14;
  localparam logic [7:0] ADDR_LAST_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_GAIN_NOW   = 8'h1C;
  // Reset values
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [7:0]  GAIN_RESET   = 8'h00;
  // Task states
  typedef enum logic [2:0] {
    RTEC_IDLE = 3'b001,
    RTEC_RUN  = 3'b010,
    RTEC_DONE = 3'b100
  } rtec_state_e;
endpackage

// File: rtl/rtec_task_end.sv
// Task end, timer capture and two-level gain control for the radio link engine
// Summary of operation
// R01: Separate transmit and receive capture selector fields
// R02: Transmit selector: off, start, end, first start
// R03: Receive selector: off, start, end, first start
// R04: Start capture taken right after sync word
// R05: Selector 11 stops capture after first packet
// R06: Receive capture may fire on rejected packets
// R07: Both directions share one captured value
// R08: Host reads capture after task completes
// R09: Completion writes cause, frees locks, interrupts
// R10: Normal end-cause codes zero to six
// R11: Error end-cause codes 249 to 255
// R12: Keep-on bit leaves synthesizer running
// R13: Host reuses synthesizer with channel 127
// R14: Halt command stops a running synthesizer
// R15: Halt command 0x01 ends task immediately
// R16: Gain control during sync search when enabled
// R17: Below low limit high, above high low
// R18: High gain captured at start, low configured
// R19: Sync found freezes gain until reception ends
// R20: Receiver off restores high gain
// R21: Reduced gain reports level plus offset
// R22: Host programs limits apart for hysteresis
// R23: Host supplies lead-in signal before packet
// R24: Gain control recommended at high rate
// R25: End cause visible by interrupt cycle
`timescale 1ns/1ps
`default_nettype none
module rtec_task_end
  import rtec_pkg::*;
#(
  parameter int TIMER_W = 32
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               task_start,
  input  wire logic               task_end,
  input  wire logic [7:0]         end_cause_in,
  input  wire logic               tx_sync_done,
  input  wire logic               tx_packet_end,
  input  wire logic               rx_sync_found,
  input  wire logic               rx_packet_end,
  input  wire logic               rx_on,
  input  wire logic               level_update,
  input  wire logic [7:0]         level_in,
  input  wire logic [TIMER_W-1:0] timer_value,
  output logic                    task_finished_irq,
  output logic                    lock_release,
  output logic                    synth_on,
  output logic                    task_active,
  output logic      [7:0]         front_end_gain
);

  // Register state
  rtec_state_e        state_reg, state_next;
  logic [31:0]        config_reg, config_next;
  logic [7:0]         cause_reg, cause_next;
  logic [TIMER_W-1:0] capture_reg, capture_next;
  logic               tx_cap_done_reg, tx_cap_done_next;
  logic               rx_cap_done_reg, rx_cap_done_next;
  logic               synth_reg, synth_next;
  logic               irq_reg, irq_next;
  logic [7:0]         high_gain_reg, high_gain_next;
  logic [7:0]         gain_reg, gain_next;
  logic [7:0]         sat_gain_reg, sat_gain_next;
  logic [7:0]         offset_reg, offset_next;
  logic [7:0]         low_lim_reg, low_lim_next;
  logic [7:0]         high_lim_reg, high_lim_next;
  logic [7:0]         last_level_reg, last_level_next;
  logic               synced_reg, synced_next;
  logic               reduced_reg, reduced_next;

  logic       wr_en;
  logic       halt_wr;
  logic [1:0] tx_sel;
  logic [1:0] rx_sel;
  logic       tx_hit;
  logic       rx_hit;
  logic       running;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign halt_wr = wr_en && (paddr == ADDR_COMMAND) && (pwdata[7:0] == HALT_COMMAND);
  assign tx_sel  = config_reg[TX_CAP_LSB +: 2];
  assign rx_sel  = config_reg[RX_CAP_LSB +: 2];
  assign running = (state_reg == RTEC_RUN);

  // Unmapped addresses answer with an error
  always_comb begin
    case (paddr)
      ADDR_CONFIG, ADDR_COMMAND, ADDR_STATUS, ADDR_CAPTURE,
      ADDR_GAIN_CFG, ADDR_LEVEL_LIM, ADDR_LAST_LEVEL, ADDR_GAIN_NOW: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // Read mux, reserved bits read as zero
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      ADDR_CONFIG:     prdata = config_reg;
      ADDR_STATUS:     prdata = {22'h0, synth_reg, running, cause_reg};
      ADDR_CAPTURE:    prdata = 32'(capture_reg);
      ADDR_GAIN_CFG:   prdata = {16'h0, offset_reg, sat_gain_reg};
      ADDR_LEVEL_LIM:  prdata = {16'h0, high_lim_reg, low_lim_reg};
      ADDR_LAST_LEVEL: prdata = {24'h0, last_level_reg};
      ADDR_GAIN_NOW:   prdata = {16'h0, high_gain_reg, gain_reg};
      default:         prdata = 32'h0000_0000;
    endcase
  end

  // Capture triggers per direction; rejected packets still trigger since address checks lie outside
  always_comb begin
    case (tx_sel) // see R02
      CAP_EVERY_START: tx_hit = tx_sync_done; // see R04
      CAP_EVERY_END:   tx_hit = tx_packet_end;
      CAP_FIRST_START: tx_hit = tx_sync_done && !tx_cap_done_reg; // see R05
      default:         tx_hit = 1'b0;
    endcase
    case (rx_sel) // see R03
      CAP_EVERY_START: rx_hit = rx_sync_found; // see R04 see R06
      CAP_EVERY_END:   rx_hit = rx_packet_end;
      CAP_FIRST_START: rx_hit = rx_sync_found && !rx_cap_done_reg; // see R05
      default:         rx_hit = 1'b0;
    endcase
  end

  // Task sequencing, capture and end cause
  always_comb begin
    state_next       = state_reg;
    config_next      = config_reg;
    cause_next       = cause_reg;
    capture_next     = capture_reg;
    tx_cap_done_next = tx_cap_done_reg;
    rx_cap_done_next = rx_cap_done_reg;
    synth_next       = synth_reg;
    irq_next         = 1'b0;
    if (wr_en && paddr == ADDR_CONFIG) begin
      config_next = pwdata; // see R01
    end
    if (running && (tx_hit || rx_hit)) begin
      capture_next = timer_value; // see R07
    end
    if (running && tx_packet_end) begin
      tx_cap_done_next = 1'b1; // see R05
    end
    if (running && rx_packet_end) begin
      rx_cap_done_next = 1'b1; // see R05
    end
    case (state_reg)
      RTEC_IDLE: begin
        if (halt_wr) begin
          synth_next = 1'b0; // see R14
        end else if (task_start) begin
          state_next       = RTEC_RUN;
          synth_next       = 1'b1;
          tx_cap_done_next = 1'b0;
          rx_cap_done_next = 1'b0;
        end
      end
      RTEC_RUN: begin
        if (halt_wr) begin
          state_next = RTEC_DONE; // see R15
          cause_next = END_ABORTED; // see R10
          synth_next = 1'b0; // see R14
        end else if (task_end) begin
          state_next = RTEC_DONE;
          cause_next = end_cause_in; // see R09 see R10 see R11
          synth_next = config_reg[SYNTH_KEEP_BIT]; // see R12
        end
      end
      RTEC_DONE: begin
        // Cause already stored, so the interrupt never leads it
        irq_next   = 1'b1; // see R25
        state_next = RTEC_IDLE;
        // A halt landing in the wrap-up cycle must not be lost, or a kept synthesizer would run on
        if (halt_wr) begin
          synth_next = 1'b0; // see R14
        end
      end
      default: state_next = RTEC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= RTEC_IDLE;
      config_reg      <= CONFIG_RESET;
      cause_reg       <= END_NORMAL;
      capture_reg     <= '0;
      tx_cap_done_reg <= 1'b0;
      rx_cap_done_reg <= 1'b0;
      synth_reg       <= 1'b0;
      irq_reg         <= 1'b0;
    end else begin
      state_reg       <= state_next;
      config_reg      <= config_next;
      cause_reg       <= cause_next;
      capture_reg     <= capture_next;
      tx_cap_done_reg <= tx_cap_done_next;
      rx_cap_done_reg <= rx_cap_done_next;
      synth_reg       <= synth_next;
      irq_reg         <= irq_next;
    end
  end

  // Interrupt and lock release share the done pulse
  assign task_finished_irq = irq_reg; // see R09
  assign lock_release      = irq_reg; // see R09
  assign synth_on          = synth_reg;
  assign task_active       = running;
  assign front_end_gain    = gain_reg;

  // Gain control next state
  always_comb begin
    high_gain_next  = high_gain_reg;
    gain_next       = gain_reg;
    sat_gain_next   = sat_gain_reg;
    offset_next     = offset_reg;
    low_lim_next    = low_lim_reg;
    high_lim_next   = high_lim_reg;
    last_level_next = last_level_reg;
    synced_next     = synced_reg;
    reduced_next    = reduced_reg;
    if (wr_en && paddr == ADDR_GAIN_CFG) begin
      sat_gain_next = pwdata[7:0];
      offset_next   = pwdata[15:8];
    end
    if (wr_en && paddr == ADDR_LEVEL_LIM) begin
      low_lim_next  = pwdata[7:0];
      high_lim_next = pwdata[15:8];
    end
    if (wr_en && paddr == ADDR_GAIN_NOW && !running) begin
      gain_next = pwdata[7:0];
    end
    if (state_reg == RTEC_IDLE && task_start) begin
      high_gain_next = gain_reg; // see R18
      synced_next    = 1'b0;
      reduced_next   = 1'b0;
    end else if (running && rx_on) begin
      if (rx_sync_found) begin
        synced_next = 1'b1; // see R19
      end else if (config_reg[GAIN_EN_BIT] && !synced_reg && level_update) begin // see R16
        if (level_in < low_lim_reg) begin
          gain_next = high_gain_reg; // see R17
        end else if (level_in > high_lim_reg) begin
          gain_next = sat_gain_reg; // see R17 see R18
        end
      end
      if (rx_packet_end) begin
        // Corrected value only; the raw level input is never altered
        last_level_next = reduced_reg ? 8'(level_in + offset_reg) : level_in; // see R21
        synced_next     = 1'b0; // see R19
      end
      reduced_next = (gain_next != high_gain_reg);
    end else if (running && !rx_on) begin
      gain_next    = high_gain_reg; // see R20
      synced_next  = 1'b0;
      reduced_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_gain_reg  <= GAIN_RESET;
      gain_reg       <= GAIN_RESET;
      sat_gain_reg   <= GAIN_RESET;
      offset_reg     <= 8'h00;
      low_lim_reg    <= 8'h00;
      high_lim_reg   <= 8'h00;
      last_level_reg <= 8'h00;
      synced_reg     <= 1'b0;
      reduced_reg    <= 1'b0;
    end else begin
      high_gain_reg  <= high_gain_next;
      gain_reg       <= gain_next;
      sat_gain_reg   <= sat_gain_next;
      offset_reg     <= offset_next;
      low_lim_reg    <= low_lim_next;
      high_lim_reg   <= high_lim_next;
      last_level_reg <= last_level_next;
      synced_reg     <= synced_next;
      reduced_reg    <= reduced_next;
    end
  end

  // Checks
  chk_irq_after_end: assert property (@(posedge pclk) disable iff (!presetn)
    (running && task_end && !halt_wr) |=> ##1 task_finished_irq) else $error("irq missing after end"); // see R09
  chk_cause_stored: assert property (@(posedge pclk) disable iff (!presetn)
    (running && task_end && !halt_wr) |=> ##1 (cause_reg == $past(end_cause_in, 2))) else $error("cause wrong"); // see R25
  chk_halt_abort: assert property (@(posedge pclk) disable iff (!presetn)
    (running && halt_wr) |=> (cause_reg == END_ABORTED && !synth_on && !running)) else $error("halt failed"); // see R15
  chk_halt_synth: assert property (@(posedge pclk) disable iff (!presetn)
    halt_wr |=> !synth_on) else $error("synth kept after halt"); // see R14
  chk_keep_synth: assert property (@(posedge pclk) disable iff (!presetn)
    (running && task_end && !halt_wr) |=> (synth_on == $past(config_reg[SYNTH_KEEP_BIT]))) else $error("keep-on wrong"); // see R12
  chk_first_only: assert property (@(posedge pclk) disable iff (!presetn)
    (running && tx_sel == CAP_FIRST_START && rx_sel == CAP_OFF && tx_cap_done_reg) |=> $stable(capture_reg))
    else $error("capture after first"); // see R05
  chk_tx_start_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (running && tx_sel == CAP_EVERY_START && tx_sync_done) |=> (capture_reg == $past(timer_value)))
    else $error("start capture missed"); // see R04
  chk_gain_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    (running && rx_on && synced_reg && !rx_sync_found && $stable(rx_on)) |=> $stable(gain_reg))
    else $error("gain changed after sync"); // see R19
  chk_gain_restore: assert property (@(posedge pclk) disable iff (!presetn)
    (running && !rx_on && !(wr_en && paddr == ADDR_GAIN_NOW)) |=> (gain_reg == high_gain_reg))
    else $error("gain not restored"); // see R20
  chk_gain_low: assert property (@(posedge pclk) disable iff (!presetn)
    (running && rx_on && config_reg[GAIN_EN_BIT] && !synced_reg && !rx_sync_found && level_update
     && level_in > high_lim_reg && level_in >= low_lim_reg) |=> (gain_reg == $past(sat_gain_reg)))
    else $error("low gain not chosen"); // see R17

endmodule
`default_nettype wire
